// >>> spimd_top.sv
`timescale 1ns/1ns
// ==========================================================
// dma serial master: buffers, counters, format
// ==========================================================
// Function
// - count bytes moved per direction each transaction, readable, up to 0x3ff
// - transmit fetch limit writable, up to 0x3ff, never read past it
// - per direction list select: 0 single buffer, 1 array of buffers
// - transmit bytes fetched from memory starting at pointer at 0x544
// - bit order: 0 most significant first, 1 least significant first
// - phase 0 samples leading, shifts trailing; 1 the reverse
// - polarity 0 active high clock, 1 active low; idle opposite
// - past transmit buffer end send over-read character per extra byte
// - received bytes stored at receive pointer, at most receive limit
module spimd_top
   import spimd_pkg::*;
(
   // system clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   // link clock
   input  wire logic        i_link_clk,
   // register port
   input  wire logic [11:0] i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   // memory port, read data in the same cycle as o_mem_rd
   output logic      [31:0] o_mem_addr,
   output logic             o_mem_rd,
   output logic             o_mem_wr,
   output logic      [7:0]  o_mem_wdata,
   input  wire logic [7:0]  i_mem_rdata,
   // status
   output logic             o_busy,
   // serial pins
   output logic             o_sck,
   output logic             o_mosi,
   input  wire logic        i_miso
);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FETCH,
      ST_FWAIT,
      ST_SEND,
      ST_WAIT,
      ST_STORE
   } spimd_state_t;

   // sequencer state
   spimd_state_t     state_r;

   // software visible registers
   logic [31:0]      rx_ptr_r;
   logic [31:0]      tx_ptr_r;
   logic [CNT_W-1:0] rx_lim_r;
   logic [CNT_W-1:0] tx_lim_r;
   logic [CNT_W-1:0] rx_amt_r;
   logic [CNT_W-1:0] tx_amt_r;
   logic             rx_list_r;
   logic             tx_list_r;
   logic [2:0]       cfg_r;
   logic [7:0]       orc_r;

   // transaction progress and byte staging
   logic [CNT_W-1:0] idx_r;
   logic [CNT_W-1:0] tot_r;
   logic [7:0]       tx_byte_r;
   logic [7:0]       rx_byte_r;
   logic             req_tgl_r;
   logic             ack_seen_r;

   // decoded strobe and crossing nets
   logic             start;
   logic             ack_s;
   logic             link_rst;
   logic [3:0]       link_ctl;
   logic             ack_tgl;
   logic [7:0]       link_rx;
   logic             last_byte;

   // link reset stretch
   logic [3:0]       rst_hold_r;
   logic             link_rst_req_r;

   // start is honoured only when idle
   assign start = i_wr && i_addr == OFS_CTRL && i_wdata[CTRL_START]
                  && state_r == ST_IDLE;
   assign last_byte = (idx_r + 10'h001) == tot_r;

   // ==========================================================
   // register writes
   // ==========================================================
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         rx_ptr_r  <= RST_PTR;
         rx_lim_r  <= RST_CNT;
         rx_list_r <= RST_LIST;
         tx_ptr_r  <= RST_PTR;
         tx_lim_r  <= RST_CNT;
         tx_list_r <= RST_LIST;
         cfg_r     <= RST_CFG;
         orc_r     <= RST_ORC;
      end else if (state_r == ST_STORE && last_byte) begin
         // array mode steps to next buffer
         if (rx_list_r == LIST_ARRAY) begin
            rx_ptr_r <= rx_ptr_r + {22'h0, rx_lim_r};
         end
         if (tx_list_r == LIST_ARRAY) begin
            tx_ptr_r <= tx_ptr_r + {22'h0, tx_lim_r};
         end
      end else if (i_wr) begin
         case (i_addr)
            OFS_RX_PTR:  rx_ptr_r  <= i_wdata;
            OFS_RX_LIM:  rx_lim_r  <= i_wdata[CNT_W-1:0];
            OFS_RX_LIST: rx_list_r <= i_wdata[0];
            OFS_TX_PTR:  tx_ptr_r  <= i_wdata;
            OFS_TX_LIM:  tx_lim_r  <= i_wdata[CNT_W-1:0];
            OFS_TX_LIST: tx_list_r <= i_wdata[0];
            OFS_CFG:     cfg_r     <= i_wdata[2:0];
            OFS_ORC:     orc_r     <= i_wdata[7:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // register reads, data one cycle after the strobe
   // ==========================================================
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_rd) begin
         case (i_addr)
            OFS_RX_PTR:  o_rdata <= rx_ptr_r;
            OFS_RX_LIM:  o_rdata <= {22'h0, rx_lim_r};
            OFS_RX_AMT:  o_rdata <= {22'h0, rx_amt_r};
            OFS_RX_LIST: o_rdata <= {31'h0, rx_list_r};
            OFS_TX_PTR:  o_rdata <= tx_ptr_r;
            OFS_TX_LIM:  o_rdata <= {22'h0, tx_lim_r};
            OFS_TX_AMT:  o_rdata <= {22'h0, tx_amt_r};
            OFS_TX_LIST: o_rdata <= {31'h0, tx_list_r};
            OFS_CFG:     o_rdata <= {29'h0, cfg_r};
            OFS_ORC:     o_rdata <= {24'h0, orc_r};
            OFS_CTRL:    o_rdata <= {31'h0, state_r != ST_IDLE};
            // unmapped offsets read as zero
            default:     o_rdata <= 32'h0000_0000;
         endcase
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end

   // ==========================================================
   // transaction sequencer and memory port
   // ==========================================================
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_r     <= ST_IDLE;
         idx_r       <= RST_CNT;
         tot_r       <= RST_CNT;
         rx_amt_r    <= RST_CNT;
         tx_amt_r    <= RST_CNT;
         tx_byte_r   <= 8'h00;
         rx_byte_r   <= 8'h00;
         req_tgl_r   <= 1'b0;
         ack_seen_r  <= 1'b0;
         o_mem_addr  <= 32'h0000_0000;
         o_mem_rd    <= 1'b0;
         o_mem_wr    <= 1'b0;
         o_mem_wdata <= 8'h00;
         o_busy      <= 1'b0;
      end else begin
         o_mem_rd <= 1'b0;
         o_mem_wr <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (start) begin
                  tot_r    <= (tx_lim_r > rx_lim_r) ? tx_lim_r : rx_lim_r;
                  idx_r    <= RST_CNT;
                  rx_amt_r <= RST_CNT;
                  tx_amt_r <= RST_CNT;
                  // both limits zero: nothing to clock
                  if (tx_lim_r != RST_CNT || rx_lim_r != RST_CNT) begin
                     state_r <= ST_FETCH;
                     o_busy  <= 1'b1;
                  end
               end
            end
            ST_FETCH: begin
               if (idx_r < tx_lim_r) begin
                  o_mem_addr <= tx_ptr_r + {22'h0, idx_r};
                  o_mem_rd   <= 1'b1;
                  tx_amt_r   <= tx_amt_r + 10'h001;
                  state_r    <= ST_FWAIT;
               end else begin
                  tx_byte_r <= orc_r;
                  state_r   <= ST_SEND;
               end
            end
            ST_FWAIT: begin
               tx_byte_r <= i_mem_rdata;
               state_r   <= ST_SEND;
            end
            ST_SEND: begin
               // byte held in tx_byte_r until the ack returns
               req_tgl_r <= ~req_tgl_r;
               state_r   <= ST_WAIT;
            end
            ST_WAIT: begin
               if (ack_s != ack_seen_r) begin
                  ack_seen_r <= ack_s;
                  rx_byte_r  <= link_rx;
                  state_r    <= ST_STORE;
               end
            end
            ST_STORE: begin
               // store below receive limit, else discard
               if (idx_r < rx_lim_r) begin
                  o_mem_addr  <= rx_ptr_r + {22'h0, idx_r};
                  o_mem_wr    <= 1'b1;
                  o_mem_wdata <= rx_byte_r;
                  rx_amt_r    <= rx_amt_r + 10'h001;
               end
               idx_r <= idx_r + 10'h001;
               if (last_byte) begin
                  state_r <= ST_IDLE;
                  o_busy  <= 1'b0;
               end else begin
                  state_r <= ST_FETCH;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // domain crossings
   // ==========================================================
   // reset count: the link clock is slower, so a short pulse could pass unseen
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         rst_hold_r <= LRST_HOLD;
      end else if (rst_hold_r != 4'h0) begin
         rst_hold_r <= rst_hold_r - 4'h1;
      end
   end

   // registered request, so the synchroniser sees no glitch
   always_ff @(posedge i_clk) begin
      link_rst_req_r <= i_sys_rst || (rst_hold_r != 4'h0);
   end

   // reset into the link domain, stretched
   spimd_sync #(.W(1)) u_rst_sync (
      .i_clk (i_link_clk),
      .i_d   (link_rst_req_r),
      .o_q   (link_rst)
   );

   // request toggle and format levels; format writes are taken even while busy
   spimd_sync #(.W(4)) u_ctl_sync (
      .i_clk (i_link_clk),
      .i_d   ({req_tgl_r, cfg_r}),
      .o_q   (link_ctl)
   );

   // completion toggle back; rx byte is steady once it flips
   spimd_sync #(.W(1)) u_ack_sync (
      .i_clk (i_clk),
      .i_d   (ack_tgl),
      .o_q   (ack_s)
   );

   // ==========================================================
   // serial engine
   // ==========================================================
   // one byte per eight clocks
   spimd_shift u_shift (
      .i_link_clk (i_link_clk),
      .i_rst      (link_rst),
      .i_req_tgl  (link_ctl[3]),
      .i_tx_byte  (tx_byte_r),
      .o_ack_tgl  (ack_tgl),
      .o_rx_byte  (link_rx),
      .i_order    (link_ctl[CFG_ORDER]),
      .i_clock_phase_sel     (link_ctl[CFG_CLOCK_PHASE_SEL]),
      .i_clock_polarity_sel     (link_ctl[CFG_CLOCK_POLARITY_SEL]),
      .i_miso     (i_miso),
      .o_sck      (o_sck),
      .o_mosi     (o_mosi)
   );

endmodule // spimd_top

// >>> spimd_pkg.sv
// ==========================================================
// shared constants of the dma serial master slice
// ==========================================================
package spimd_pkg;

   // register map, byte offsets
   localparam logic [11:0] OFS_RX_PTR  = 12'h534;
   localparam logic [11:0] OFS_RX_LIM  = 12'h538;
   localparam logic [11:0] OFS_RX_AMT  = 12'h53c;
   localparam logic [11:0] OFS_RX_LIST = 12'h540;
   localparam logic [11:0] OFS_TX_PTR  = 12'h544;
   localparam logic [11:0] OFS_TX_LIM  = 12'h548;
   localparam logic [11:0] OFS_TX_AMT  = 12'h54c;
   localparam logic [11:0] OFS_TX_LIST = 12'h550;
   localparam logic [11:0] OFS_CFG     = 12'h554;
   localparam logic [11:0] OFS_ORC     = 12'h5c0;
   localparam logic [11:0] OFS_CTRL    = 12'h600;

   // field layout
   localparam int CNT_W      = 10;
   localparam int CFG_ORDER  = 0;
   localparam int CFG_CLOCK_PHASE_SEL   = 1;
   localparam int CFG_CLOCK_POLARITY_SEL   = 2;
   localparam int CTRL_START = 0;
   localparam int CTRL_BUSY  = 0;

   // reset values
   localparam logic [31:0]      RST_PTR  = 32'h0000_0000;
   localparam logic [CNT_W-1:0] RST_CNT  = 10'h000;
   localparam logic [2:0]       RST_CFG  = 3'h0;
   localparam logic [7:0]       RST_ORC  = 8'h00;
   localparam logic             RST_LIST = 1'b0;

   // list selector encoding
   localparam logic LIST_ARRAY = 1'b1;

   // serial timing on the link clock
   localparam int LINK_PERIOD_NS = 30;
   localparam int SCK_HALF_NS    = 120;
   localparam int SCK_HALF_CYC   = SCK_HALF_NS / LINK_PERIOD_NS;
   localparam logic [2:0] SCK_LAST  = 3'(SCK_HALF_CYC - 1);
   localparam logic [2:0] MISO_SAMP = 3'h2;
   localparam logic [4:0] EDGES     = 5'h10;

   // system cycles that reset is stretched for the link side
   localparam logic [3:0] LRST_HOLD = 4'hf;

endpackage

// >>> spimd_sync.sv
`timescale 1ns/1ns
// ==========================================================
// two-stage level synchroniser, one per bit
// ==========================================================
module spimd_sync #(
   parameter int W = 1
) (
   // clock
   input  wire logic         i_clk,
   // levels
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic meta_r;
         logic hold_r;
         // first stage feeds only the second
         always_ff @(posedge i_clk) begin
            meta_r <= i_d[g];
            hold_r <= meta_r;
         end
         assign o_q[g] = hold_r;
      end
   endgenerate

endmodule // spimd_sync

// >>> spimd_shift.sv
`timescale 1ns/1ns
// ==========================================================
// serial byte engine on the link clock
// ==========================================================
module spimd_shift
   import spimd_pkg::*;
(
   // link clock and synchronised reset
   input  wire logic       i_link_clk,
   input  wire logic       i_rst,
   // byte handshake, data held stable by sender
   input  wire logic       i_req_tgl,
   input  wire logic [7:0] i_tx_byte,
   output logic            o_ack_tgl,
   output logic      [7:0] o_rx_byte,
   // frame format, synchronised levels
   input  wire logic       i_order,
   input  wire logic       i_clock_phase_sel,
   input  wire logic       i_clock_polarity_sel,
   // serial pins
   input  wire logic       i_miso,
   output logic            o_sck,
   output logic            o_mosi
);

   logic       req_d_r;
   logic       active_r;
   logic [2:0] hc_r;
   logic [4:0] ph_r;
   logic [7:0] sh_r;
   logic [7:0] rx_r;
   logic       samp_r;
   logic       miso_s;
   logic       lead;
   logic       shift_edge;

   // miso comes from the pin, so two flops first
   spimd_sync #(.W(1)) u_miso (
      .i_clk (i_link_clk),
      .i_d   (i_miso),
      .o_q   (miso_s)
   );

   assign lead       = ~ph_r[0];
   assign shift_edge = (lead == i_clock_phase_sel);

   // ==========================================================
   // shifting, clocking and sampling
   // ==========================================================
   always_ff @(posedge i_link_clk) begin
      if (i_rst) begin
         req_d_r   <= 1'b0;
         active_r  <= 1'b0;
         hc_r      <= 3'h0;
         ph_r      <= 5'h00;
         sh_r      <= 8'h00;
         rx_r      <= 8'h00;
         samp_r    <= 1'b0;
         o_ack_tgl <= 1'b0;
         o_rx_byte <= 8'h00;
         o_sck     <= 1'b0;
         o_mosi    <= 1'b0;
      end else if (!active_r) begin
         o_sck <= i_clock_polarity_sel;
         if (i_req_tgl != req_d_r) begin
            req_d_r  <= i_req_tgl;
            active_r <= 1'b1;
            hc_r     <= 3'h0;
            ph_r     <= 5'h00;
            if (!i_clock_phase_sel) begin
               o_mosi <= i_order ? i_tx_byte[0] : i_tx_byte[7];
               sh_r   <= i_order ? (i_tx_byte >> 1) : (i_tx_byte << 1);
            end else begin
               sh_r <= i_tx_byte;
            end
         end
      end else begin
         hc_r <= hc_r + 3'h1;
         // sample three cycles after the edge, before the slave moves
         if (samp_r && hc_r == MISO_SAMP) begin
            samp_r <= 1'b0;
            rx_r <= i_order ? {miso_s, rx_r[7:1]} : {rx_r[6:0], miso_s};
         end
         if (hc_r == SCK_LAST) begin
            hc_r <= 3'h0;
            if (ph_r != EDGES) begin
               o_sck <= ~o_sck;
               ph_r  <= ph_r + 5'h01;
               if (shift_edge) begin
                  o_mosi <= i_order ? sh_r[0] : sh_r[7];
                  sh_r   <= i_order ? (sh_r >> 1) : (sh_r << 1);
               end else begin
                  samp_r <= 1'b1;
               end
            end else begin
               // tail half period lets the last sample land
               active_r  <= 1'b0;
               o_rx_byte <= rx_r;
               o_ack_tgl <= ~o_ack_tgl;
            end
         end
      end
   end

endmodule // spimd_shift

// >>> spimd_properties.sv
`timescale 1ns/1ns
// ==========================================================
// port checker of the dma serial master
// ==========================================================
module spimd_chk
   import spimd_pkg::*;
(
   // clocks and reset
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_link_clk,
   // register port
   input  wire logic [11:0] i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic [31:0] o_rdata,
   // memory port
   input  wire logic [31:0] o_mem_addr,
   input  wire logic        o_mem_rd,
   input  wire logic        o_mem_wr,
   input  wire logic [7:0]  o_mem_wdata,
   input  wire logic [7:0]  i_mem_rdata,
   // status and pins
   input  wire logic        o_busy,
   input  wire logic        o_sck,
   input  wire logic        o_mosi,
   input  wire logic        i_miso
);
   logic [9:0] txl_r;
   logic [9:0] rxl_r;
   logic [9:0] rdn_r;
   logic [9:0] wrn_r;
   logic [2:0] cfg_r;
   logic [4:0] idle_r;
   // mirror of limits and format; written on any write, idle or busy
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         txl_r <= RST_CNT;
         rxl_r <= RST_CNT;
         cfg_r <= RST_CFG;
      end else if (i_wr) begin
         if (i_addr == OFS_TX_LIM) txl_r <= i_wdata[CNT_W-1:0];
         if (i_addr == OFS_RX_LIM) rxl_r <= i_wdata[CNT_W-1:0];
         if (i_addr == OFS_CFG) cfg_r <= i_wdata[2:0];
      end
   end
   // memory accesses within the running transaction
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || !o_busy) begin
         rdn_r <= 10'h000;
         wrn_r <= 10'h000;
      end else begin
         rdn_r <= rdn_r + 10'(o_mem_rd);
         wrn_r <= wrn_r + 10'(o_mem_wr);
      end
   end
   // idle time, long enough for the link side to settle
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || o_busy || (i_wr && i_addr == OFS_CFG)) idle_r <= 5'h00;
      else if (idle_r != 5'h1f) idle_r <= idle_r + 5'h01;
   end

   chk_rd_window: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_rdata != 32'h0 |-> $past(i_rd)) else $error("read data outside its cycle");
   chk_tx_limit: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_mem_rd |-> rdn_r < txl_r) else $error("fetch past transmit limit");
   chk_rx_limit: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_mem_wr |-> wrn_r < rxl_r) else $error("store past receive limit");
   chk_mem_excl: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_mem_rd |-> !o_mem_wr ##1 !o_mem_rd) else $error("memory strobes collide");
   chk_cfg_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $past(i_rd) && $past(i_addr) == OFS_CFG |-> o_rdata == {29'h0, cfg_r})
      else $error("format read wrong");
   chk_sck_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      idle_r == 5'h1f |-> o_sck == cfg_r[CFG_CLOCK_POLARITY_SEL]) else $error("clock idle level wrong");
   chk_start_run: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_wr && i_addr == OFS_CTRL && i_wdata[CTRL_START] && !o_busy && (txl_r | rxl_r) != 0
      |-> ##[1:3] o_busy) else $error("start did not run");
   chk_sample_still: assert property (@(posedge i_link_clk) disable iff (i_sys_rst)
      o_busy && $changed(o_sck) && ((o_sck != cfg_r[CFG_CLOCK_POLARITY_SEL]) != cfg_r[CFG_CLOCK_PHASE_SEL])
      |-> $stable(o_mosi)) else $error("data moved on sample edge");

   // main scenarios
   cov_mode3: cover property (@(posedge i_clk) $rose(o_busy) && cfg_r == 3'h7);
   cov_store: cover property (@(posedge i_clk) o_mem_wr);
   cov_fetch: cover property (@(posedge i_clk) o_mem_rd ##1 !o_mem_rd);
endmodule // spimd_chk

bind spimd_top spimd_chk u_chk (
   .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_link_clk(i_link_clk), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_mem_addr(o_mem_addr),
   .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata),
   .i_mem_rdata(i_mem_rdata), .o_busy(o_busy), .o_sck(o_sck), .o_mosi(o_mosi),
   .i_miso(i_miso)
);

// >>> spimd_slave_model.sv
`timescale 1ns/1ns
// ==========================================================
// behavioural serial slave at the far end
// ==========================================================
module spimd_slave_model
   import spimd_pkg::*;
(
   // serial pins
   input  wire logic       i_sck,
   input  wire logic       i_mosi,
   output logic            o_miso,
   // format programmed in the master
   input  wire logic [2:0] i_fmt
);
   logic [7:0] rx_log [0:15];
   logic [7:0] sh;
   logic [7:0] rep;
   int         nbit;
   int         nrx;
   // bit position of the k-th bit on the wire
   function automatic int pos(input int k);
      return i_fmt[CFG_ORDER] ? k : 7 - k;
   endfunction
   // no select line, so the bench marks the frame start
   task automatic arm(input logic [7:0] r);
      rep = r;
      nbit = 0;
      nrx = 0;
      o_miso = r[pos(0)];
   endtask
   // edge roles from polarity and phase
   always @(i_sck) begin
      if ((i_sck != i_fmt[CFG_CLOCK_POLARITY_SEL]) != i_fmt[CFG_CLOCK_PHASE_SEL]) begin
         sh[pos(nbit)] = i_mosi;
         nbit = nbit + 1;
         if (nbit == 8) begin
            rx_log[nrx[3:0]] = sh;
            nrx = nrx + 1;
            rep = rep + 8'h01;
            nbit = 0;
            // hold runs out after the last bit
            if (i_fmt[CFG_CLOCK_PHASE_SEL]) o_miso <= #100 ~o_miso;
         end
      end else begin
         o_miso = rep[pos(nbit)];
      end
   end
endmodule // spimd_slave_model

// >>> testbench.sv
`timescale 1ns/1ns
// ==========================================================
// self-checking bench of the dma serial master
// ==========================================================
module testbench
   import spimd_pkg::*;
;
   logic        i_clk, i_sys_rst, i_link_clk, i_wr, i_rd, i_miso, rd_q;
   logic        o_mem_rd, o_mem_wr, o_busy, o_sck, o_mosi;
   logic [11:0] i_addr;
   logic [31:0] i_wdata, o_rdata, o_mem_addr, seed, v, wv, txp, rxp;
   logic [7:0]  o_mem_wdata, i_mem_rdata, junk;
   logic [7:0]  mem [0:4095];
   logic [2:0]  fmt;
   int          miscompares, checks_done, nrd, nwr;
   logic [11:0] regs [0:9] = '{OFS_RX_PTR, OFS_RX_LIM, OFS_RX_AMT, OFS_RX_LIST, OFS_TX_PTR,
                               OFS_TX_LIM, OFS_TX_AMT, OFS_TX_LIST, OFS_CFG, OFS_ORC};

   spimd_top i_dut (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_link_clk(i_link_clk), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
      .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata), .o_busy(o_busy),
      .o_sck(o_sck), .o_mosi(o_mosi), .i_miso(i_miso));
   spimd_slave_model u_far (.i_sck(o_sck), .i_mosi(o_mosi), .o_miso(i_miso), .i_fmt(fmt));

   // clocks, link clock off in phase
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   initial begin
      i_link_clk = 1'b0;
      #7;
      forever #15 i_link_clk = ~i_link_clk;
   end
   // memory answers at once and holds a cycle; junk otherwise
   assign i_mem_rdata = (o_mem_rd || rd_q) ? mem[o_mem_addr[11:0]] : junk;
   always @(posedge i_clk) begin
      rd_q <= o_mem_rd;
      junk <= ~junk + 8'h5b;
      if (o_mem_rd) nrd <= nrd + 1;
      if (o_mem_wr) mem[o_mem_addr[11:0]] <= o_mem_wdata;
      if (o_mem_wr) nwr <= nwr + 1;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // bits that a register keeps
   function automatic logic [31:0] keep_of(input logic [11:0] a);
      case (a)
         OFS_TX_LIM, OFS_RX_LIM: return 32'h0000_03ff;
         OFS_ORC: return 32'h0000_00ff;
         OFS_CFG: return 32'h0000_0007;
         OFS_TX_LIST, OFS_RX_LIST: return 32'h0000_0001;
         OFS_TX_AMT, OFS_RX_AMT: return 32'h0000_0000;
         default: return 32'hffff_ffff;
      endcase
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      v = o_rdata;
   endtask
   task automatic wait_busy(input logic lvl);
      int w;
      w = 0;
      while (o_busy !== lvl && w < 4000) begin
         @(posedge i_clk);
         w++;
      end
      if (w == 4000) begin
         miscompares = miscompares + 1;
         $display("BAD at %0t busy %h expected %h", $time, o_busy, lvl);
         close_out();
      end
   endtask
   // one transaction; keep leaves pointers as the block moved them
   task automatic run(input logic [2:0] f, input int tl, input int rl, input logic keep);
      int         n;
      logic [7:0] r0;
      logic [7:0] fill;
      r0 = 8'(rnd());
      fill = 8'(rnd());
      n = tl > rl ? tl : rl;
      for (int i = 0; i < 16; i++) mem[txp[11:0] + 12'(i)] = 8'(rnd());
      fmt = f;
      wr(OFS_CFG, 32'(f));
      if (!keep) wr(OFS_TX_PTR, txp);
      if (!keep) wr(OFS_RX_PTR, rxp);
      wr(OFS_TX_LIM, 32'(tl));
      wr(OFS_RX_LIM, 32'(rl));
      wr(OFS_ORC, 32'(fill));
      repeat (20) @(posedge i_clk);
      u_far.arm(r0);
      nrd = 0;
      nwr = 0;
      wr(OFS_CTRL, 32'h1);
      wait_busy(1'b1);
      wait_busy(1'b0);
      repeat (2) @(posedge i_clk); // last store lands first
      check(32'(u_far.nrx), 32'(n));
      for (int i = 0; i < n; i++)
         check(32'(u_far.rx_log[i]), 32'(i < tl ? mem[txp[11:0] + 12'(i)] : fill));
      for (int i = 0; i < rl; i++) check(32'(mem[rxp[11:0] + 12'(i)]), 32'(r0 + 8'(i)));
      check(32'(nrd), 32'(tl));
      check(32'(nwr), 32'(rl));
      rd(OFS_TX_AMT);
      check(v, 32'(tl));
      rd(OFS_RX_AMT);
      check(v, 32'(rl));
   endtask

   initial begin
      seed = 32'd89;
      {i_wr, i_rd, rd_q, junk, fmt, nrd, nwr} = '0;
      {i_addr, i_wdata, miscompares, checks_done} = '0;
      txp = 32'h100;
      rxp = 32'h800;
      i_sys_rst = 1'b1;
      // two cycles; the block stretches it for the link side
      repeat (2) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      // reset values, then all ones and random words
      for (int k = 0; k < 3; k++) begin
         for (int i = 0; i < 10; i++) begin
            wv = k == 1 ? 32'hffff_ffff : rnd();
            if (k > 0) wr(regs[i], wv);
            rd(regs[i]);
            check(v, k > 0 ? wv & keep_of(regs[i]) : 32'h0);
         end
      end
      $display("test registers done");
      rd(12'h004);
      check(v, 32'h0);
      $display("test unmapped done");
      wr(OFS_TX_LIM, 32'h0);
      wr(OFS_RX_LIM, 32'h0);
      wr(OFS_CTRL, 32'h1);
      repeat (4) @(posedge i_clk);
      check({31'h0, o_busy}, 32'h0);
      $display("test empty start done");
      wr(OFS_TX_LIST, 32'h0);
      wr(OFS_RX_LIST, 32'h0);
      for (int m = 0; m < 8; m++) run(3'(m), m == 0 ? 0 : m == 1 ? 3 : int'(rnd() % 4),
                                      m == 1 ? 1 : 1 + int'(rnd() % 3), 1'b0);
      $display("test formats done");
      wr(OFS_TX_LIST, 32'h1);
      wr(OFS_RX_LIST, 32'h1);
      for (int j = 0; j < 2; j++) begin
         run(3'h5, 2, 3, j[0]);
         rd(OFS_TX_PTR);
         check(v, txp + 32'h2);
         rd(OFS_RX_PTR);
         check(v, rxp + 32'h3);
         txp = txp + 32'h2;
         rxp = rxp + 32'h3;
      end
      $display("test array list done");
      close_out();
   end
endmodule // testbench
